// file: rtl/spu_core.sv
`include "spu_map.svh"

module spu_core
  import spu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  output spu_mem_s         memOut,
  input  wire logic        memAck,
  input  wire logic [63:0] memRdata
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    spu_phase_e  phase;              // Operation phase
    spu_op_e     op;                 // Command in flight
    spu_ctrl_s   ctrl;               // Mode bits
    logic [63:0] stackPointer;       // Widest form of the pointer
    logic [63:0] instructionPointer; // Return target holder
    logic [63:0] frameBasePointer;   // Frame reference
    logic [63:0] data;               // Push source, pop result
    logic [63:0] target;             // Call target, load operand
    logic [15:0] ssSel;              // Stack segment selector
    logic [1:0]  ssPriv;             // Descriptor privilege level
    logic [31:0] ssBase;             // Stack segment base
    logic        invalid;            // Last command refused
    logic        done;               // Last command finished
    spu_mem_s    mem;                // Memory request
    logic        ack;                // Bus acknowledge
    logic [31:0] rdat;               // Bus read data
  } spu_state_s;

  spu_state_s st;       // Registered state
  spu_state_s next_st;  // Value for the next edge

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Width of the top-of-stack address
  function automatic spu_width_e widthOf(spu_ctrl_s c);
    if (c.mode64)
      return SPU_W64;
    return c.ssBig ? SPU_W32 : SPU_W16;
  endfunction

  // Bytes moved by a plain push or pop
  function automatic logic [3:0] stepOf(spu_ctrl_s c);
    if (c.mode64)
      return 4'h8;
    return c.csDefault32 ? 4'h4 : 4'h2;
  endfunction

  // Merge a new pointer into the part that the width uses
  function automatic logic [63:0] fitPtr(logic [63:0] old,
                                         logic [63:0] nv,
                                         spu_width_e  w);
    unique case (w)
      SPU_W16: return {old[63:16], nv[15:0]};
      SPU_W32: return {old[63:32], nv[31:0]};
      SPU_W64: return nv;
    endcase
  endfunction

  // Linear stack address through the current stack segment
  function automatic logic [63:0] addrOf(spu_ctrl_s   c,
                                         logic [31:0] base,
                                         logic [63:0] p);
    if (c.mode64)
      return p;
    return {32'h0, base} + fitPtr(64'h0, p, widthOf(c));
  endfunction

  // Keep only the bytes that an item of this size holds
  function automatic logic [63:0] trim(logic [63:0] v,
                                       logic [3:0]  n);
    unique case (n)
      4'h2:    return {48'h0, v[15:0]};
      4'h4:    return {32'h0, v[31:0]};
      default: return v;
    endcase
  endfunction

  // Byte lane write merge for the register bus
  function automatic logic [31:0] lanes(logic [31:0] old,
                                        logic [31:0] nv,
                                        logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i])
        r[i*8 +: 8] = nv[i*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decoded bus request
  // ----------------------------------------------------------------
  logic       busReq;   // New access this cycle
  logic       cmdGo;    // Command accepted
  logic [7:0] regAdr;   // Word aligned offset
  spu_op_e    cmdCode;  // Command written
  logic       exp32;    // Explicit operand address size is 32

  assign regAdr  = {wbAdr[7:2], 2'b00};
  assign busReq  = wbCyc && wbStb && !st.ack;
  assign cmdCode = spu_op_e'(wbDatI[3:0]);
  // Commands while busy are dropped; software polls busy first
  assign cmdGo   = busReq && wbWe && wbSel[0] &&
                   regAdr == `SPU_CMD && st.phase == SPU_IDLE;
  assign exp32   = st.ctrl.csDefault32 ^ st.ctrl.prefix67;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process computes every field so no field has two drivers
  always_comb begin
    logic [63:0] newPtr;
    logic [3:0]  step;
    newPtr  = st.stackPointer;
    step    = stepOf(st.ctrl);
    next_st = st;
    next_st.ack = busReq;

    // Wide mode pins privilege to the current level
    if (st.ctrl.mode64)
      next_st.ssPriv = st.ctrl.currentPrivilegeLevel;

    // Register writes; pointer writes apply only while idle
    if (busReq && wbWe && st.phase == SPU_IDLE) begin
      unique case (regAdr)
        `SPU_CTRL: next_st.ctrl = spu_ctrl_s'(
          6'(lanes({26'h0, st.ctrl}, wbDatI, wbSel)));
        `SPU_PTR_LO: next_st.stackPointer[31:0] =
          lanes(st.stackPointer[31:0], wbDatI, wbSel);
        `SPU_PTR_HI: next_st.stackPointer[63:32] =
          lanes(st.stackPointer[63:32], wbDatI, wbSel);
        `SPU_INS_LO: next_st.instructionPointer[31:0] =
          lanes(st.instructionPointer[31:0], wbDatI, wbSel);
        `SPU_INS_HI: next_st.instructionPointer[63:32] =
          lanes(st.instructionPointer[63:32], wbDatI, wbSel);
        `SPU_FBP_LO: next_st.frameBasePointer[31:0] =
          lanes(st.frameBasePointer[31:0], wbDatI, wbSel);
        `SPU_FBP_HI: next_st.frameBasePointer[63:32] =
          lanes(st.frameBasePointer[63:32], wbDatI, wbSel);
        `SPU_DAT_LO: next_st.data[31:0] =
          lanes(st.data[31:0], wbDatI, wbSel);
        `SPU_DAT_HI: next_st.data[63:32] =
          lanes(st.data[63:32], wbDatI, wbSel);
        `SPU_SEL: next_st.ssSel =
          16'(lanes({16'h0, st.ssSel}, wbDatI, wbSel));
        `SPU_BASE: next_st.ssBase =
          lanes(st.ssBase, wbDatI, wbSel);
        `SPU_TGT_LO: next_st.target[31:0] =
          lanes(st.target[31:0], wbDatI, wbSel);
        `SPU_TGT_HI: next_st.target[63:32] =
          lanes(st.target[63:32], wbDatI, wbSel);
        default: ;  // Unmapped or command: no storage
      endcase
    end

    // Register reads; unmapped words answer zero
    unique case (regAdr)
      `SPU_CTRL:   next_st.rdat = {26'h0, st.ctrl};
      `SPU_CMD:    next_st.rdat = {28'h0, st.done, exp32,
                                   st.invalid,
                                   st.phase != SPU_IDLE};
      `SPU_PTR_LO: next_st.rdat = st.stackPointer[31:0];
      `SPU_PTR_HI: next_st.rdat = st.stackPointer[63:32];
      `SPU_INS_LO: next_st.rdat = st.instructionPointer[31:0];
      `SPU_INS_HI: next_st.rdat = st.instructionPointer[63:32];
      `SPU_FBP_LO: next_st.rdat = st.frameBasePointer[31:0];
      `SPU_FBP_HI: next_st.rdat = st.frameBasePointer[63:32];
      `SPU_DAT_LO: next_st.rdat = st.data[31:0];
      `SPU_DAT_HI: next_st.rdat = st.data[63:32];
      `SPU_SEL:    next_st.rdat = {14'h0, st.ssPriv, st.ssSel};
      `SPU_BASE:   next_st.rdat = st.ssBase;
      `SPU_TGT_LO: next_st.rdat = st.target[31:0];
      `SPU_TGT_HI: next_st.rdat = st.target[63:32];
      default:     next_st.rdat = 32'h0;
    endcase

    // Operation sequencer
    unique case (st.phase)
      SPU_IDLE: begin
        if (cmdGo) begin
          next_st.op      = cmdCode;
          next_st.done    = 1'b0;
          next_st.invalid = 1'b0;
          next_st.mem.addr = addrOf(st.ctrl, st.ssBase,
                                    st.stackPointer);
          next_st.mem.size = step;
          // No alignment test anywhere: odd pointers go out as is
          case (cmdCode)
            SPU_PUSH, SPU_PUSH16, SPU_PUSHSEG, SPU_CALL: begin
              if (cmdCode == SPU_PUSH16)
                step = 4'h2;
              newPtr = st.stackPointer - {60'h0, step};
              // Selector slots snap down to a full stack word
              if (cmdCode == SPU_PUSHSEG)
                newPtr = newPtr & ~{60'h0, step - 4'h1};
              // Pointer moves first, the write follows
              newPtr = fitPtr(st.stackPointer, newPtr,
                              widthOf(st.ctrl));
              next_st.stackPointer = newPtr;
              next_st.mem.addr  = addrOf(st.ctrl, st.ssBase,
                                         newPtr);
              next_st.mem.size  = step;
              next_st.mem.wdata = trim(st.data, step);
              if (cmdCode == SPU_PUSHSEG)
                next_st.mem.wdata = {48'h0, st.ssSel};
              if (cmdCode == SPU_CALL)
                next_st.mem.wdata =
                  trim(st.instructionPointer, step);
              next_st.mem.req = 1'b1;
              next_st.mem.we  = 1'b1;
              next_st.phase   = SPU_WRITE;
            end
            SPU_POP, SPU_RET, SPU_POP_XSEG: begin
              if (cmdCode == SPU_POP_XSEG && st.ctrl.mode64) begin
                next_st.invalid = 1'b1;
                next_st.done    = 1'b1;
              end else begin
                // Read at the current top before any move
                next_st.mem.req = 1'b1;
                next_st.mem.we  = 1'b0;
                next_st.phase   = SPU_READ;
              end
            end
            SPU_LOAD_FARSTK: begin
              // Selector and pointer change on one edge
              next_st.ssSel        = st.target[15:0];
              next_st.stackPointer = st.data;
              next_st.done         = 1'b1;
            end
            SPU_LOAD_FARDAT: begin
              // Data segment loads are outside this unit
              next_st.invalid = st.ctrl.mode64;
              next_st.done    = 1'b1;
            end
            default: begin
              next_st.invalid = 1'b1;  // Unknown command code
              next_st.done    = 1'b1;
            end
          endcase
        end
      end
      SPU_WRITE: begin
        // Hold the request until memory takes it
        if (memAck) begin
          next_st.mem.req = 1'b0;
          next_st.phase   = SPU_IDLE;
          next_st.done    = 1'b1;
          if (st.op == SPU_CALL)
            next_st.instructionPointer = st.target;
        end
      end
      SPU_READ: begin
        if (memAck) begin
          newPtr = st.stackPointer + {60'h0, step};
          next_st.stackPointer = fitPtr(st.stackPointer, newPtr,
                                        widthOf(st.ctrl));
          // Return target is taken unchecked, near or far
          if (st.op == SPU_RET)
            next_st.instructionPointer =
              trim(memRdata, step);
          else
            next_st.data = trim(memRdata, step);
          next_st.mem.req = 1'b0;
          next_st.phase   = SPU_IDLE;
          next_st.done    = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st      <= '0;
      st.ctrl <= `SPU_CTRL_RST;
      st.stackPointer <= `SPU_PTR_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wbAck  = st.ack;
  assign wbDatO = st.rdat;
  assign memOut = st.mem;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pushOrder;
    @(posedge clock) disable iff (!resetn)
      memOut.req && memOut.we |->
        memOut.addr == addrOf(st.ctrl, st.ssBase, st.stackPointer);
  endproperty
  a_pushOrder: assert property (p_pushOrder)
    else $error("push address not at moved pointer");

  property p_popOrder;
    @(posedge clock) disable iff (!resetn)
      memOut.req && !memOut.we && !memAck |=> $stable(st.stackPointer);
  endproperty
  a_popOrder: assert property (p_popOrder)
    else $error("pointer moved before pop read done");

  property p_step32;
    @(posedge clock) disable iff (!resetn)
      cmdGo && cmdCode == SPU_PUSH && st.ctrl.csDefault32 &&
      st.ctrl.ssBig && !st.ctrl.mode64 |=>
        st.stackPointer[31:0] == $past(st.stackPointer[31:0]) - 32'h4;
  endproperty
  a_step32: assert property (p_step32)
    else $error("push step not four bytes");

  property p_push16;
    @(posedge clock) disable iff (!resetn)
      cmdGo && cmdCode == SPU_PUSH16 |=> memOut.size == 4'h2;
  endproperty
  a_push16: assert property (p_push16)
    else $error("short push size wrong");

  property p_segAlign;
    @(posedge clock) disable iff (!resetn)
      cmdGo && cmdCode == SPU_PUSHSEG && st.ctrl.csDefault32 |=>
        st.stackPointer[1:0] == 2'b00;
  endproperty
  a_segAlign: assert property (p_segAlign)
    else $error("selector push left pointer unaligned");

  property p_base64;
    @(posedge clock) disable iff (!resetn)
      memOut.req && st.ctrl.mode64 |-> memOut.addr == st.stackPointer;
  endproperty
  a_base64: assert property (p_base64)
    else $error("wide mode address not base zero");

  property p_priv;
    @(posedge clock) disable iff (!resetn)
      st.ctrl.mode64 ##1 $stable(st.ctrl) |->
        st.ssPriv == st.ctrl.currentPrivilegeLevel;
  endproperty
  a_priv: assert property (p_priv)
    else $error("privilege level not tracking current");

  property p_inval;
    @(posedge clock) disable iff (!resetn)
      cmdGo && st.ctrl.mode64 && cmdCode == SPU_POP_XSEG |=>
        st.invalid && !memOut.req;
  endproperty
  a_inval: assert property (p_inval)
    else $error("segment pop not refused in wide mode");

  property p_farLoad;
    @(posedge clock) disable iff (!resetn)
      cmdGo && cmdCode == SPU_LOAD_FARSTK |=>
        st.ssSel == $past(st.target[15:0]) &&
        // Selector and pointer must both land on the same edge
        st.stackPointer == $past(st.data);
  endproperty
  a_farLoad: assert property (p_farLoad)
    else $error("far stack load not atomic");

  c_call: cover property (@(posedge clock)
    cmdGo && cmdCode == SPU_CALL ##[1:20] memAck);
  c_ret: cover property (@(posedge clock)
    cmdGo && cmdCode == SPU_RET ##[1:20] memAck);
  c_seg64: cover property (@(posedge clock)
    cmdGo && cmdCode == SPU_PUSHSEG && st.ctrl.mode64);
endmodule

// file: rtl/spu_map.svh
`ifndef SPU_MAP_SVH
`define SPU_MAP_SVH
// Notes on behaviour
// - Push decrements pointer, then writes item
// - Pop reads item, then increments pointer
// - Step follows code default size bit
// - Sixteen-bit push moves pointer two bytes
// - Selector push aligns down to the push step size
// - No alignment check, no fault raised
// - Sixteen-bit address size uses low pointer
// - Thirty-two-bit address size uses low 32 pointer bits
// - Stack size bit picks 16 or 32
// - Explicit operand size from D xor prefix
// - Stack accesses go through stack segment
// - Far stack load sets selector, pointer together
// - One stack segment up to full size
// - Call pushes return pointer before jumping
// - Return pops saved pointer and resumes
// - Popped return value used without checks
// - Wide mode treats segment base as zero
// - Wide mode keeps privilege equal current
// - Wide mode pointers are 64 bits
// - Wide mode steps eight, aligns selector
// - Wide mode rejects some segment loads

// Register byte offsets
`define SPU_CTRL    8'h00
`define SPU_CMD     8'h04
`define SPU_PTR_LO  8'h08
`define SPU_PTR_HI  8'h0c
`define SPU_INS_LO  8'h10
`define SPU_INS_HI  8'h14
`define SPU_FBP_LO  8'h18
`define SPU_FBP_HI  8'h1c
`define SPU_DAT_LO  8'h20
`define SPU_DAT_HI  8'h24
`define SPU_SEL     8'h28
`define SPU_BASE    8'h2c
`define SPU_TGT_LO  8'h30
`define SPU_TGT_HI  8'h34

// Status field positions
`define SPU_ST_BUSY  0
`define SPU_ST_INVAL 1
`define SPU_ST_EXP32 2
`define SPU_ST_DONE  3

// Reset values
`define SPU_CTRL_RST 6'h00
`define SPU_PTR_RST  64'h0
`endif

// file: rtl/spu_pkg.sv
package spu_pkg;
  // Core phase of a stack operation
  typedef enum logic [1:0] {
    SPU_IDLE,
    SPU_WRITE,
    SPU_READ
  } spu_phase_e;

  // Commands written to the command register
  typedef enum logic [3:0] {
    SPU_PUSH,
    SPU_PUSH16,
    SPU_PUSHSEG,
    SPU_POP,
    SPU_POP_XSEG,
    SPU_CALL,
    SPU_RET,
    SPU_LOAD_FARSTK,
    SPU_LOAD_FARDAT
  } spu_op_e;

  // Pointer width in force
  typedef enum logic [1:0] {
    SPU_W16,
    SPU_W32,
    SPU_W64
  } spu_width_e;

  // Mode bits set by software
  typedef struct packed {
    logic [1:0] currentPrivilegeLevel;
    logic       prefix67;
    logic       mode64;
    logic       ssBig;
    logic       csDefault32;
  } spu_ctrl_s;

  // Request toward the memory system
  typedef struct packed {
    logic        req;
    logic        we;
    logic [63:0] addr;
    logic [63:0] wdata;
    logic [3:0]  size;
  } spu_mem_s;
endpackage

// file: test/spu_core_tb_top.sv
`include "spu_map.svh"

`define SPU_CHK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
      nErrors++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module spu_core_tb_top
  import spu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Expected memory request, with a flag to check size and data too
  typedef struct packed {
    logic     full;
    spu_mem_s m;
  } spu_exp_s;

  logic        clock   = 1'b0;
  logic        resetn  = 1'b0;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [7:0]  wbAdr   = 8'h00;
  logic [3:0]  wbSel   = 4'h0;
  logic [31:0] wbDatI  = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck;
  spu_mem_s    memOut;
  logic        memAck;
  logic [63:0] memRdata;
  logic [1:0]  latency = 2'h0;
  int          nErrors;
  int          samplesChecked;
  int          seed    = 93;
  logic [32:0] rdQ [$];  // {check, value} per register read
  spu_exp_s    memQ [$]; // Memory requests in issue order
  logic [31:0] r;
  logic [31:0] p;
  logic [31:0] d;

  always #50 clock = ~clock;

  spu_core uut (
    .clock    (clock),
    .resetn   (resetn),
    .wbCyc    (wbCyc),
    .wbStb    (wbStb),
    .wbWe     (wbWe),
    .wbAdr    (wbAdr),
    .wbSel    (wbSel),
    .wbDatI   (wbDatI),
    .wbDatO   (wbDatO),
    .wbAck    (wbAck),
    .memOut   (memOut),
    .memAck   (memAck),
    .memRdata (memRdata)
  );

  spu_mem_model mem (
    .clock    (clock),
    .resetn   (resetn),
    .memOut   (memOut),
    .latency  (latency),
    .memAck   (memAck),
    .memRdata (memRdata)
  );

  // ------------------------------------------------------------
  // Verdict and end of run
  // ------------------------------------------------------------
  task automatic finalReport();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Classic Wishbone cycle, held until ack is sampled
  // ------------------------------------------------------------
  task automatic wbXfer(input logic w, input logic [7:0] a,
                        input logic [31:0] dat, output logic [31:0] q);
    int i;
    @(posedge clock);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbSel  <= 4'hf;
    wbDatI <= dat;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    q = wbDatO;
    if (wbAck !== 1'b1) begin
      nErrors++;
      $display("[FAIL] %0t bus ack timeout", $time);
      finalReport();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] q;
    wbXfer(1'b1, a, dat, q);
  endtask

  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask

  // Every read leaves a note, so the monitor stays in step
  task automatic rd(input logic [7:0] a, input logic c,
                    input logic [31:0] e, output logic [31:0] q);
    rdQ.push_back({c, e});
    wbXfer(1'b0, a, 32'h0, q);
  endtask

  task automatic expMem(input logic w, input logic [63:0] a,
                        input logic [63:0] v, input logic [3:0] s,
                        input logic f);
    spu_exp_s e;
    e.full    = f;
    e.m.req   = 1'b1;
    e.m.we    = w;
    e.m.addr  = a;
    e.m.wdata = v;
    e.m.size  = s;
    memQ.push_back(e);
  endtask

  // Issue a command and poll until done with busy clear
  task automatic runCmd(input spu_op_e op);
    logic [31:0] s;
    int          i;
    latency <= 2'($random(seed));
    wr(`SPU_CMD, {28'h0, op});
    for (i = 0; i < 40; i++) begin
      rd(`SPU_CMD, 1'b0, 32'h0, s);
      if (s[`SPU_ST_DONE] === 1'b1 && s[`SPU_ST_BUSY] === 1'b0) break;
    end
    if (i == 40) begin
      nErrors++;
      $display("[FAIL] %0t command never finished", $time);
      finalReport();
    end
  endtask

  // ------------------------------------------------------------
  // Read monitor: oldest note against the acked read data
  // ------------------------------------------------------------
  always @(posedge clock) begin
    logic [32:0] n;
    if (wbAck === 1'b1 && wbWe === 1'b0 && rdQ.size() > 0) begin
      n = rdQ.pop_front();
      if (n[32]) `SPU_CHK(wbDatO, n[31:0])
    end
  end

  // ------------------------------------------------------------
  // Memory monitor: each answered request against its note
  // ------------------------------------------------------------
  always @(posedge clock) begin
    spu_exp_s e;
    if (memOut.req === 1'b1 && memAck === 1'b1) begin
      if (memQ.size() == 0) begin
        nErrors++;
        $display("[FAIL] %0t unexpected memory request", $time);
      end else begin
        e = memQ.pop_front();
        `SPU_CHK(memOut.we, e.m.we)
        `SPU_CHK(memOut.addr, e.m.addr)
        if (e.full) begin
          `SPU_CHK(memOut.size, e.m.size)
          `SPU_CHK(memOut.wdata, e.m.wdata)
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(`SPU_CTRL, 1'b1, 32'h0, r);
    rd(`SPU_PTR_LO, 1'b1, 32'h0, r);
    // Unmapped place reads zero after a write
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, 1'b1, 32'h0, r);
    // Wide stack, 32-bit code default, segment base 1000h
    wr(`SPU_CTRL, 32'h03);
    wr(`SPU_BASE, 32'h1000);
    wr(`SPU_SEL, 32'h0123);
    wr64(`SPU_PTR_LO, 64'h200);
    wr64(`SPU_DAT_LO, 64'hdeadbeef);
    expMem(1'b1, 64'h11fc, 64'hdeadbeef, 4'h4, 1'b1);
    runCmd(SPU_PUSH);
    rd(`SPU_PTR_LO, 1'b1, 32'h1fc, r);
    rd(`SPU_CMD, 1'b1, 32'hc, r);
    wr64(`SPU_DAT_LO, 64'h0);
    expMem(1'b0, 64'h11fc, 64'h0, 4'h4, 1'b0);
    runCmd(SPU_POP);
    rd(`SPU_DAT_LO, 1'b1, 32'hdeadbeef, r);
    rd(`SPU_PTR_LO, 1'b1, 32'h200, r);
    // Half-width push leaves the pointer off alignment
    expMem(1'b1, 64'h11fe, 64'hbeef, 4'h2, 1'b1);
    runCmd(SPU_PUSH16);
    // Selector push: 1feh - 4 = 1fah, lands on 1f8h
    expMem(1'b1, 64'h11f8, 64'h0123, 4'h4, 1'b1);
    runCmd(SPU_PUSHSEG);
    rd(`SPU_PTR_LO, 1'b1, 32'h1f8, r);
    // Call and return through the stack
    wr64(`SPU_PTR_LO, 64'h200);
    wr64(`SPU_INS_LO, 64'h4000);
    wr64(`SPU_TGT_LO, 64'h8000);
    expMem(1'b1, 64'h11fc, 64'h4000, 4'h4, 1'b1);
    runCmd(SPU_CALL);
    rd(`SPU_INS_LO, 1'b1, 32'h8000, r);
    expMem(1'b0, 64'h11fc, 64'h0, 4'h4, 1'b0);
    runCmd(SPU_RET);
    rd(`SPU_INS_LO, 1'b1, 32'h4000, r);
    // Random, often misaligned pointers; no fault may follow
    for (int i = 0; i < 6; i++) begin
      p = ($random(seed) & 32'h7ffffff3) | 32'h100;
      d = $random(seed);
      wr64(`SPU_PTR_LO, {32'h0, p});
      wr64(`SPU_DAT_LO, {32'h0, d});
      expMem(1'b1, 64'h1000 + p - 4, {32'h0, d}, 4'h4, 1'b1);
      runCmd(SPU_PUSH);
      rd(`SPU_CMD, 1'b1, 32'hc, r);
      expMem(1'b0, 64'h1000 + p - 4, 64'h0, 4'h4, 1'b0);
      runCmd(i[0] ? SPU_POP : SPU_RET);
      rd(i[0] ? `SPU_DAT_LO : `SPU_INS_LO, 1'b1, d, r);
      rd(`SPU_PTR_LO, 1'b1, p, r);
    end
    // Both stack pointer and selector in one command
    wr64(`SPU_TGT_LO, 64'h0055);
    wr64(`SPU_DAT_LO, 64'h3000);
    runCmd(SPU_LOAD_FARSTK);
    rd(`SPU_SEL, 1'b1, 32'h0055, r);
    rd(`SPU_PTR_LO, 1'b1, 32'h3000, r);
    // Narrow stack wraps within the low 16 pointer bits
    wr(`SPU_CTRL, 32'h00);
    wr64(`SPU_PTR_LO, 64'habcd0000);
    expMem(1'b1, 64'h10ffe, 64'h3000, 4'h2, 1'b1);
    runCmd(SPU_PUSH);
    // Wide mode, privilege 2, prefix toggles the operand size
    wr(`SPU_CTRL, 32'h2f);
    wr64(`SPU_PTR_LO, 64'h1_0000_0010);
    wr64(`SPU_DAT_LO, 64'h1122334455667788);
    expMem(1'b1, 64'h1_0000_0008, 64'h1122334455667788, 4'h8,
           1'b1);
    runCmd(SPU_PUSH);
    rd(`SPU_PTR_HI, 1'b1, 32'h1, r);
    rd(`SPU_SEL, 1'b1, 32'h20055, r);
    wr64(`SPU_PTR_LO, 64'h1_0000_000c);
    expMem(1'b1, 64'h1_0000_0000, 64'h55, 4'h8, 1'b1);
    runCmd(SPU_PUSHSEG);
    runCmd(SPU_LOAD_FARDAT);
    rd(`SPU_CMD, 1'b1, 32'ha, r);
    runCmd(SPU_POP_XSEG);
    rd(`SPU_CMD, 1'b1, 32'ha, r);
    `SPU_CHK(memQ.size(), 0)
    finalReport();
  end
endmodule

// file: test/spu_mem_model.sv
module spu_mem_model
  import spu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire spu_mem_s    memOut,
  input  wire logic [1:0]  latency,
  output logic             memAck,
  output logic      [63:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] store [logic [63:0]]; // Sparse byte image of the stack
  logic [1:0] waitCnt;              // Cycles spent on the open request

  // ------------------------------------------------------------
  // Answer each request after the latency that the bench chose
  // ------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      memAck   <= 1'b0;
      memRdata <= 64'h0;
      waitCnt  <= 2'h0;
    end else begin
      memAck   <= 1'b0;
      // Idle data toggles, so stale bytes never pass for a match
      memRdata <= ~memRdata;
      if (memOut.req && !memAck) begin
        if (waitCnt >= latency) begin
          waitCnt <= 2'h0;
          memAck  <= 1'b1;
          for (int i = 0; i < 8; i++) begin
            // Full 64-bit address space, one flat segment
            if (memOut.we && i < memOut.size) begin
              store[memOut.addr + 64'(i)] = memOut.wdata[8*i +: 8];
            end
            // Bytes beyond the size carry junk the core must drop
            if (i < memOut.size && store.exists(memOut.addr + 64'(i))) begin
              memRdata[8*i +: 8] <= store[memOut.addr + 64'(i)];
            end else begin
              memRdata[8*i +: 8] <= 8'hc3 ^ 8'(i);
            end
          end
        end else begin
          waitCnt <= waitCnt + 2'h1;
        end
      end
    end
  end
endmodule
